// ---- logic/discrete_input_totalizer.sv ----
// three discrete inputs: noise filter, pulse totalizer, runtime and gated rate,
// status lamps, all behind an AHB-Lite slave with zero wait states
// assumes inputs are already synchronous to hclk and a single slave on the bus
// How it works
// - three independent input channels share one common and one clock
// - filtered inputs need a stable level 12.5 ms, limiting counting to 40 Hz
// - inputs one and two can bypass the filter for counting up to 5 kHz
// - enabled filter on inputs one and two acts as normal; input three always filtered
// - each OFF-to-ON transition increments the totalizer, independent of bus traffic
// - totalizers are 32 bits and wrap to zero
// - host may clear or preset a totalizer anytime; counting continues from it
// - ON time accumulates per input in whole seconds
// - runtime accumulators are 32 bits and wrap to zero
// - host write to a runtime register clears or presets it
// - host programs the gate interval; rate updates once per gate interval
// - gate end copies interval counts to rate registers and restarts them from zero
// - one lamp per input, lit while the input is ON
// - input states readable as three bits, each forceable by the host
`timescale 1ns/1ns
module discrete_input_totalizer #(
  parameter int FILTER_CYC = dit_pkg::FILTER_CYCLES,
  parameter int MS_CYC     = dit_pkg::MS_CYCLES
) (
  input  wire logic                            hclk,
  input  wire logic                            hresetn,
  input  wire logic                            hsel,
  input  wire logic                            hready,
  input  wire logic [1:0]                      htrans,
  input  wire logic                            hwrite,
  input  wire logic [2:0]                      hsize,
  input  wire logic [31:0]                     haddr,
  input  wire logic [31:0]                     hwdata,
  output logic      [31:0]                     hrdata,
  output logic                                 hreadyout,
  output logic                                 hresp,
  input  wire logic [dit_pkg::NUM_INPUTS-1:0]  din,
  output logic      [dit_pkg::NUM_INPUTS-1:0]  led
);
  import dit_pkg::*;

  typedef struct packed {
    logic [NUM_INPUTS-1:0][19:0] filt_cnt;
    logic [NUM_INPUTS-1:0]       filt;
    logic [NUM_INPUTS-1:0]       prev;
    logic [NUM_INPUTS-1:0]       filt_en;
    logic [NUM_INPUTS-1:0]       force_en;
    logic [NUM_INPUTS-1:0]       force_val;
    logic [GATE_W-1:0]           gate;
    logic [GATE_W-1:0]           gate_cnt;
    logic [23:0]                 ms_cnt;
    logic [9:0]                  ms_in_sec;
    logic [NUM_INPUTS-1:0][31:0] total;
    logic [NUM_INPUTS-1:0][31:0] runtime;
    logic [NUM_INPUTS-1:0][31:0] icount;
    logic [NUM_INPUTS-1:0][31:0] rate;
    logic [31:0]                 rdata;
    logic                        dp_write;
    logic [7:0]                  dp_addr;
  } state_t;

  state_t                s;
  state_t                next_s;
  logic [NUM_INPUTS-1:0] on;
  logic [NUM_INPUTS-1:0] rise;
  logic [NUM_INPUTS-1:0] wr_total;
  logic [NUM_INPUTS-1:0] wr_runtime;
  logic                  ms_tick;
  logic                  sec_tick;
  logic                  gate_end;
  logic                  addr_phase;
  logic [GATE_W-1:0]     gate_eff;

  function automatic reg_sel_t decode(input logic [7:0] a);
    reg_sel_t r;
    r = REG_NONE;
    if (a[1:0] == 2'h0) begin
      unique case (a)
        ADDR_CTRL:      r = REG_CTRL;
        ADDR_STATE:     r = REG_STATE;
        ADDR_FORCE_EN:  r = REG_FORCE_EN;
        ADDR_FORCE_VAL: r = REG_FORCE_VAL;
        ADDR_GATE:      r = REG_GATE;
        default: begin
          if (a[3:2] != 2'h3) begin
            if (a[7:4] == ADDR_TOTAL[7:4]) r = REG_TOTAL;
            if (a[7:4] == ADDR_RUNTIME[7:4]) r = REG_RUNTIME;
            if (a[7:4] == ADDR_RATE[7:4]) r = REG_RATE;
          end
        end
      endcase
    end
    return r;
  endfunction

  function automatic logic [31:0] read_reg(input logic [7:0] a, input state_t st);
    logic [31:0] d;
    logic [1:0]  ch;
    d  = 32'h0;
    ch = a[3:2];
    unique case (decode(a))
      REG_CTRL:      d = {29'h0, st.filt_en};
      REG_STATE:     d = {29'h0, (st.prev & ~st.force_en) | (st.force_val & st.force_en)};
      REG_FORCE_EN:  d = {29'h0, st.force_en};
      REG_FORCE_VAL: d = {29'h0, st.force_val};
      REG_GATE:      d = {16'h0, st.gate};
      REG_TOTAL:     d = st.total[ch];
      REG_RUNTIME:   d = st.runtime[ch];
      REG_RATE:      d = st.rate[ch];
      REG_NONE:      d = 32'h0;
    endcase
    return d;
  endfunction

  assign addr_phase = hsel && hready && htrans[1];
  // a gate of zero would never end, so it counts as one millisecond
  assign gate_eff   = (s.gate == 16'h0) ? 16'h0001 : s.gate;

  always_comb begin
    next_s     = s;
    on         = '0;
    rise       = '0;
    wr_total   = '0;
    wr_runtime = '0;
    ms_tick    = 1'b0;
    sec_tick   = 1'b0;
    gate_end   = 1'b0;

    // time bases; the second is built from the millisecond so both stay in step
    if (s.ms_cnt == 24'(MS_CYC - 1)) begin
      next_s.ms_cnt = 24'h0;
      ms_tick       = 1'b1;
    end else begin
      next_s.ms_cnt = s.ms_cnt + 24'h1;
    end
    if (ms_tick) begin
      if (s.ms_in_sec == 10'(MS_PER_SEC - 1)) begin
        next_s.ms_in_sec = 10'h0;
        sec_tick         = 1'b1;
      end else begin
        next_s.ms_in_sec = s.ms_in_sec + 10'h1;
      end
      if (s.gate_cnt + 16'h1 >= gate_eff) begin
        next_s.gate_cnt = 16'h0;
        gate_end        = 1'b1;
      end else begin
        next_s.gate_cnt = s.gate_cnt + 16'h1;
      end
    end

    // register writes land in the data phase
    if (s.dp_write) begin
      unique case (decode(s.dp_addr))
        REG_CTRL:      next_s.filt_en = {1'b1, hwdata[CTRL_FILT_EN_LSB +: FAST_INPUTS]};
        REG_FORCE_EN:  next_s.force_en = hwdata[NUM_INPUTS-1:0];
        REG_FORCE_VAL: next_s.force_val = hwdata[NUM_INPUTS-1:0];
        REG_GATE:      next_s.gate = hwdata[GATE_W-1:0];
        REG_TOTAL:     wr_total[s.dp_addr[3:2]] = 1'b1;
        REG_RUNTIME:   wr_runtime[s.dp_addr[3:2]] = 1'b1;
        REG_STATE, REG_RATE, REG_NONE: begin
        end
      endcase
    end

    for (int i = 0; i < NUM_INPUTS; i++) begin
      // a level must hold for the whole filter time before it is accepted
      if (s.filt[i] == din[i]) begin
        next_s.filt_cnt[i] = 20'h0;
      end else if (s.filt_cnt[i] == 20'(FILTER_CYC - 1)) begin
        next_s.filt[i]     = din[i];
        next_s.filt_cnt[i] = 20'h0;
      end else begin
        next_s.filt_cnt[i] = s.filt_cnt[i] + 20'h1;
      end
      on[i]          = s.filt_en[i] ? s.filt[i] : din[i];
      rise[i]        = on[i] & ~s.prev[i];
      next_s.prev[i] = on[i];

      // an edge in the cycle of a preset is added on top, so none is lost
      if (wr_total[i]) begin
        next_s.total[i] = hwdata + 32'(rise[i]);
      end else begin
        next_s.total[i] = s.total[i] + 32'(rise[i]);
      end
      if (wr_runtime[i]) begin
        next_s.runtime[i] = hwdata + 32'(sec_tick & on[i]);
      end else begin
        next_s.runtime[i] = s.runtime[i] + 32'(sec_tick & on[i]);
      end
      if (gate_end) begin
        next_s.rate[i]   = s.icount[i] + 32'(rise[i]);
        next_s.icount[i] = 32'h0;
      end else begin
        next_s.icount[i] = s.icount[i] + 32'(rise[i]);
      end
    end

    // zero wait state: read data is captured at the address phase
    next_s.dp_write = addr_phase && hwrite;
    next_s.dp_addr  = haddr[7:0];
    next_s.rdata    = (addr_phase && !hwrite) ? read_reg(haddr[7:0], s) : 32'h0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // filters start enabled so contact bounce is never counted before setup
      s         <= '0;
      s.filt_en <= FILT_EN_RESET;
      s.gate    <= GATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata    = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign led       = s.prev;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rise0_quiet;
    rise[0] && !wr_total[0];
  endsequence

  sequence on0_at_second;
    sec_tick && on[0] && !wr_runtime[0];
  endsequence

  // a changed level whose counter has reached the end of the filter time
  sequence filt1_accept;
    s.filt[1] != din[1] && s.filt_cnt[1] == 20'(FILTER_CYC - 1);
  endsequence

  // bus write to the second totalizer, then its data phase with no edge on that input
  sequence total1_write;
    addr_phase && hwrite && haddr[7:0] == ADDR_TOTAL + 8'h4 ##1 !rise[1];
  endsequence

  // read of the state word while the first input is forced
  sequence state_read_forced;
    addr_phase && !hwrite && haddr[7:0] == ADDR_STATE && s.force_en[0];
  endsequence

  total_count_a: assert property (rise0_quiet |=> s.total[0] == $past(s.total[0]) + 32'h1)
    else $error("totalizer missed a rising edge");
  total_wrap_a: assert property (rise0_quiet and (s.total[0] == 32'hffffffff) |=> s.total[0] == 32'h0)
    else $error("totalizer did not wrap to zero");
  total_preset_a: assert property (wr_total[1] && !rise[1] |=> s.total[1] == $past(hwdata))
    else $error("totalizer preset not taken");
  runtime_tick_a: assert property (on0_at_second |=> s.runtime[0] == $past(s.runtime[0]) + 32'h1)
    else $error("runtime did not advance on an ON second");
  runtime_hold_a: assert property (!sec_tick && !wr_runtime[2] |=> $stable(s.runtime[2]))
    else $error("runtime moved between second ticks");
  runtime_preset_a: assert property (wr_runtime[2] && !sec_tick |=> s.runtime[2] == $past(hwdata))
    else $error("runtime preset not taken");
  rate_hold_a: assert property (!gate_end |=> $stable(s.rate))
    else $error("rate changed outside a gate end");
  rate_copy_a: assert property (gate_end |=> s.icount[1] == 32'h0 &&
    s.rate[1] == $past(s.icount[1]) + 32'($past(rise[1])))
    else $error("rate copy or interval restart wrong");
  fast_bypass_a: assert property (!s.filt_en[0] && din[0] && !s.prev[0] |=> s.prev[0] && led[0])
    else $error("unfiltered input not followed");
  third_filtered_a: assert property (1'b1 |=> s.prev[2] == $past(s.filt[2]))
    else $error("third input bypassed its filter");
  lamp_follow_a: assert property (1'b1 |=> led == $past(on))
    else $error("lamp does not track input state");

  // the filter only moves once its counter has run the full hold time
  filter_accept_a: assert property (filt1_accept |=> s.filt[1] == $past(din[1]))
    else $error("filtered level not accepted after the hold time");
  filter_reject_a: assert property (s.filt_cnt[1] != 20'(FILTER_CYC - 1) |=> $stable(s.filt[1]))
    else $error("filtered level changed before the hold time");
  filter_clear_a: assert property (s.filt[0] == din[0] |=> s.filt_cnt[0] == 20'h0)
    else $error("filter hold count not cleared on a matching level");
  filtered_follow_a: assert property (s.filt_en[1] |=> s.prev[1] == $past(s.filt[1]))
    else $error("enabled filter on the second input bypassed");
  third_enable_a: assert property (s.filt_en[2])
    else $error("third input filter enable cleared");
  runtime_wrap_a: assert property (on0_at_second and s.runtime[0] == 32'hffffffff |=> s.runtime[0] == 32'h0)
    else $error("runtime did not wrap to zero");
  runtime_idle_a: assert property (sec_tick && !on[1] && !wr_runtime[1] |=> $stable(s.runtime[1]))
    else $error("runtime advanced while the input was OFF");
  second_tick_a: assert property (sec_tick |-> ms_tick)
    else $error("second tick off the millisecond grid");
  gate_tick_a: assert property (gate_end |-> ms_tick)
    else $error("gate ended off the millisecond grid");
  icount_count_a: assert property (!gate_end |=> s.icount[1] == $past(s.icount[1]) + 32'($past(rise[1])))
    else $error("interval count missed an edge");
  rate_restart_a: assert property (gate_end |=> s.icount[0] == 32'h0 && s.icount[2] == 32'h0)
    else $error("interval counts not restarted at gate end");
  total_hold_a: assert property (!rise[2] && !wr_total[2] |=> $stable(s.total[2]))
    else $error("totalizer moved without an edge");
  total_bus_write_a: assert property (total1_write |=> s.total[1] == $past(hwdata))
    else $error("totalizer bus write not taken");
  state_force_a: assert property (state_read_forced |=> hrdata[0] == $past(s.force_val[0]))
    else $error("forced state bit not read back");
  read_idle_a: assert property (!(addr_phase && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  lamp_off_a: assert property (!on[0] |=> !led[0])
    else $error("lamp lit while the input is OFF");
endmodule

// ---- logic/dit_pkg.sv ----
// constants shared by the discrete input totalizer and its bench
// assumes one 10 MHz clock and a 32-bit AHB-Lite register window
package dit_pkg;
  localparam int NUM_INPUTS    = 3;
  localparam int FAST_INPUTS   = 2;
  localparam int CLK_PERIOD_NS = 100;

  // slow time bases
  localparam int TICK_MS_NS    = 1000000;
  localparam int MS_CYCLES     = TICK_MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_SEC    = 1000;

  // the input must hold a new level this long before it is accepted;
  // a full period then takes at least twice this, i.e. 40 Hz
  localparam int FILTER_US     = 12500;
  localparam int FILTER_CYCLES = (FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATE     = 8'h04;
  localparam logic [7:0] ADDR_FORCE_EN  = 8'h08;
  localparam logic [7:0] ADDR_FORCE_VAL = 8'h0c;
  localparam logic [7:0] ADDR_GATE      = 8'h10;
  localparam logic [7:0] ADDR_TOTAL     = 8'h20;
  localparam logic [7:0] ADDR_RUNTIME   = 8'h30;
  localparam logic [7:0] ADDR_RATE      = 8'h40;

  // field layout and reset values
  localparam int          CTRL_FILT_EN_LSB = 0;
  localparam logic [2:0]  FILT_EN_RESET    = 3'h7;
  localparam int          GATE_W           = 16;
  localparam logic [15:0] GATE_RESET       = 16'h03e8;

  typedef enum logic [3:0] {
    REG_NONE      = 4'h0,
    REG_CTRL      = 4'h1,
    REG_STATE     = 4'h2,
    REG_FORCE_EN  = 4'h3,
    REG_FORCE_VAL = 4'h4,
    REG_GATE      = 4'h5,
    REG_TOTAL     = 4'h6,
    REG_RUNTIME   = 4'h7,
    REG_RATE      = 4'h8
  } reg_sel_t;
endpackage

// ---- tb/bus_host.sv ----
// host side of the register bus: single word transfers on AHB-Lite
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/1ns
module bus_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      haddr,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b1;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    haddr  = 32'h0;
    hwdata = 32'h0;
  end

  // call just after a rising edge; released lines show inverted data so stale values never match
  // presets of counters, runtime and gate all go through here
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr  <= ~a;
    hwdata <= w ? wd : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the discrete input totalizer
// assumes the filter and millisecond counts are shortened to 4 and 5 cycles
`timescale 1ns/1ns
module tb_top;
  import dit_pkg::*;
  logic                  hclk    = 1'b0;
  logic                  hresetn = 1'b0;
  logic                  hsel;
  logic                  hwrite;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           haddr;
  logic [31:0]           hwdata;
  logic [31:0]           hrdata;
  logic                  hreadyout;
  logic                  hresp;
  logic [NUM_INPUTS-1:0] din = 3'h0;
  logic [NUM_INPUTS-1:0] led;
  int                    errors = 0;
  int                    checks = 0;

  always #50 hclk = ~hclk;

  discrete_input_totalizer #(.FILTER_CYC(4), .MS_CYC(5)) discrete_input_totalizer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hready(hreadyout), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .din(din), .led(led));

  bus_host bus_host_i (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .haddr(haddr), .hwdata(hwdata));

  task automatic finish_test;
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus_host_i.xfer(1'b1, {24'h0, a}, d, rd);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus_host_i.xfer(1'b0, {24'h0, a}, 32'h0, rd);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // n pulses, each level held len cycles
  task automatic pulse(input int idx, input int n, input int len);
    repeat (n) begin
      din[idx] <= 1'b1;
      repeat (len) @(posedge hclk);
      din[idx] <= 1'b0;
      repeat (len) @(posedge hclk);
    end
  endtask

  task automatic t_reset;
    rd_chk(ADDR_CTRL, 32'h7);
    rd_chk(ADDR_GATE, {16'h0, GATE_RESET});
    rd_chk(ADDR_TOTAL + 8'h8, 32'h0);
    rd_chk(ADDR_RUNTIME, 32'h0);
    rd_chk(8'hfc, 32'h0);
    wr(ADDR_GATE, 32'h2);
  endtask

  // short pulses are noise, long ones count, on both a switchable and the fixed input
  task automatic t_filter;
    for (int i = 1; i < NUM_INPUTS; i++) begin
      pulse(i, 3, 2);
      pulse(i, 2, 8);
      rd_chk(ADDR_TOTAL + 8'(4 * i), 32'h2);
    end
    din[2] <= 1'b1;
    repeat (8) @(posedge hclk);
    chk({29'h0, led}, 32'h4);
    din[2] <= 1'b0;
    repeat (8) @(posedge hclk);
    chk({29'h0, led}, 32'h0);
  endtask

  task automatic t_count;
    wr(ADDR_CTRL, 32'h0);
    pulse(0, 5, 1);
    rd_chk(ADDR_TOTAL, 32'h5);
    wr(ADDR_TOTAL, 32'hffffffff);
    pulse(0, 1, 1);
    rd_chk(ADDR_TOTAL, 32'h0);
    wr(ADDR_TOTAL + 8'h4, 32'h12345678);
    rd_chk(ADDR_TOTAL + 8'h4, 32'h12345678);
    wr(ADDR_RUNTIME + 8'h8, 32'h00000abc);
    rd_chk(ADDR_RUNTIME + 8'h8, 32'h00000abc);
  endtask

  // any 5000-cycle ON window holds exactly one second tick
  task automatic t_runtime;
    wr(ADDR_RUNTIME, 32'hffffffff);
    din[0] <= 1'b1;
    repeat (5000) @(posedge hclk);
    din[0] <= 1'b0;
    repeat (4) @(posedge hclk);
    rd_chk(ADDR_RUNTIME, 32'h0);
    rd_chk(ADDR_TOTAL, 32'h1);
  endtask

  // period of 2 cycles against a 10-cycle gate: 5 rises in every gate
  task automatic t_rate;
    fork
      pulse(1, 40, 1);
      begin
        repeat (50) @(posedge hclk);
        rd_chk(ADDR_RATE + 8'h4, 32'h5);
      end
    join
  endtask

  task automatic t_force;
    din <= 3'h2;
    wr(ADDR_FORCE_EN, 32'h1);
    wr(ADDR_FORCE_VAL, 32'h1);
    wr(ADDR_STATE, 32'h0);
    rd_chk(ADDR_STATE, 32'h3);
    chk({29'h0, led}, 32'h2);
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_filter;
    t_count;
    t_runtime;
    t_rate;
    t_force;
    finish_test;
  end

  initial begin
    #3000000;
    errors++;
    finish_test;
  end
endmodule
